//--- cio_blink.sv
// Class-then-code blink sequencer for the status LED
`timescale 1ns/1ps
`include "cio_map.svh"
module cio_blink
  import cio_pkg::*;
#(
  parameter int unsigned SLOT_CYC = `CIO_BLINK_CYC
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Sequencer port
  cio_led_if.seq   led
);
  cio_blink_t  state;
  logic [31:0] slot_cnt;
  logic [3:0]  left;
  wire         slot_end = (slot_cnt == SLOT_CYC - 1);

  ////////////////////////////////////////////////////////////////////////////
  // Slot timer
  always_ff @(posedge aclk) begin
    if (!aresetn || state == CIO_IDLE || slot_end) begin
      slot_cnt <= 32'h0;
    end else begin
      slot_cnt <= slot_cnt + 32'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequence: class blinks, gap, code blinks, pause, repeat
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= CIO_IDLE;
      left  <= 4'h0;
    end else if (!led.fault_on) begin
      state <= CIO_IDLE;
    end else begin
      unique case (state)
        CIO_IDLE: begin
          state <= CIO_CLS_ON;
          left  <= {1'b0, led.fault_class};
        end
        CIO_CLS_ON: if (slot_end) begin
          state <= CIO_CLS_OF;
          left  <= left - 4'h1;
        end
        CIO_CLS_OF: if (slot_end) begin
          state <= (left == 4'h0) ? CIO_GAP : CIO_CLS_ON;
        end
        CIO_GAP: if (slot_end) begin
          state <= CIO_COD_ON;
          left  <= {1'b0, led.fault_code};
        end
        CIO_COD_ON: if (slot_end) begin
          state <= CIO_COD_OF;
          left  <= left - 4'h1;
        end
        CIO_COD_OF: if (slot_end) begin
          if (left == 4'h0) begin
            state <= CIO_PAUSE;
            left  <= `CIO_PAUSE_SLOTS;
          end else begin
            state <= CIO_COD_ON;
          end
        end
        CIO_PAUSE: if (slot_end) begin
          left <= left - 4'h1;
          if (left == 4'h1) begin
            state <= CIO_IDLE;
          end
        end
        default: state <= CIO_IDLE;
      endcase
    end
  end

  assign led.blink_busy = (state != CIO_IDLE) || led.fault_on;
  assign led.class_led  = (state == CIO_CLS_ON);
  assign led.code_led   = (state == CIO_COD_ON);

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  class_first_a: assert property (@(posedge aclk) disable iff (!aresetn)
    state == CIO_IDLE && led.fault_on |=> state == CIO_CLS_ON)
    else $error("Class blinks did not start first");
  repeat_pause_a: assert property (@(posedge aclk) disable iff (!aresetn)
    led.fault_on && state == CIO_COD_OF && slot_end &&
    left == 4'h0 |=>
    state == CIO_PAUSE && !led.code_led)
    else $error("No pause after code blinks");
endmodule

//--- cio_far_end.sv
// Far-side model: isolated input sources and status LED observer
`timescale 1ns/1ps
module cio_far_end #(
  parameter int unsigned SLOT_CYC = 4
) (
  // Clock
  input  wire logic  aclk,
  // Voltages applied at the connector inputs
  input  wire logic  drive_one,
  input  wire logic  drive_two,
  output logic       iso_one,
  output logic       iso_two,
  // LEDs and decoded blink counts
  input  wire logic  class_led,
  input  wire logic  code_led,
  output logic [3:0] class_blinks,
  output logic [3:0] code_blinks,
  output int         pauses
);
  logic [3:0] run_cls;
  logic [3:0] run_cod;
  logic       last_cls;
  logic       last_cod;
  int         dark;

  // The isolator inverts every input
  assign iso_one = ~drive_one;
  assign iso_two = ~drive_two;

  initial begin
    {run_cls, run_cod, last_cls, last_cod} = '0;
    {class_blinks, code_blinks} = '0;
    dark = 0;
    pauses = 0;
  end

  // A long dark run marks the pause; one repetition's counts latch there
  always @(posedge aclk) begin
    last_cls <= class_led;
    last_cod <= code_led;
    dark <= (class_led | code_led) ? 0 : dark + 1;
    if (dark == 5 * SLOT_CYC) begin
      class_blinks <= run_cls;
      code_blinks <= run_cod;
      run_cls <= 4'h0;
      run_cod <= 4'h0;
      pauses <= pauses + 1;
    end else begin
      if (class_led && !last_cls) run_cls <= run_cls + 4'h1;
      if (code_led && !last_cod) run_cod <= run_cod + 4'h1;
    end
  end
endmodule

//--- cio_led_if.sv
// Fault request and LED drive between the top and the blink sequencer
`timescale 1ns/1ps
interface cio_led_if;
  logic       fault_on;
  logic [2:0] fault_class;
  logic [2:0] fault_code;
  logic       blink_busy;
  logic       class_led;
  logic       code_led;

  modport ctrl (output fault_on, fault_class, fault_code,
                input  blink_busy, class_led, code_led);
  modport seq  (input  fault_on, fault_class, fault_code,
                output blink_busy, class_led, code_led);
endinterface

//--- cio_map.svh
// Register map, field positions, codes and timing counts of the camera I/O block
`ifndef CIO_MAP_SVH
`define CIO_MAP_SVH

`define CIO_OFF_INP1     12'h300
`define CIO_OFF_INP2     12'h304
`define CIO_OFF_CTRL     12'h310
`define CIO_OFF_FAULT    12'h314
`define CIO_OFF_OUTSEL   12'h318
`define CIO_OFF_STATUS   12'h31c
`define CIO_OFF_IRQ      12'h320
`define CIO_OFF_MASK     12'h324

`define CIO_BIT_PRESENT  0
`define CIO_BIT_POL      7
`define CIO_MODE_LO      11
`define CIO_MODE_HI      15
`define CIO_BIT_PIN      31
`define CIO_INP_RESET    32'h00000001
`define CIO_INP1_MODE    5'h02
`define CIO_MODE_TRIG    5'h02

`define CIO_CTRL_EXT     0
`define CIO_CTRL_ARM     1
`define CIO_CTRL_READY   2
`define CIO_CTRL_PORT    3

`define CIO_OUT_LOW      3'h0
`define CIO_OUT_INTEGRATION_ACTIVE_OUTPUT   3'h1
`define CIO_OUT_IN2      3'h2
`define CIO_OUT_BUSY     3'h3
`define CIO_OUT_TRIG     3'h4
`define CIO_OUTSEL_RESET 12'h0d1

`define CIO_EV_CAPTURE   0
`define CIO_EV_FAULT     1
`define CIO_EV_IN1       2
`define CIO_EV_IN2       3

`define CIO_RESP_OKAY    2'b00
`define CIO_RESP_SLVERR  2'b10

`define CIO_CLK_HZ       20000000
`define CIO_BLINK_MS     250
`define CIO_BLINK_CYC    ((`CIO_CLK_HZ / 1000) * `CIO_BLINK_MS)
`define CIO_PAUSE_SLOTS  4'h6

`endif

//--- cio_pkg.sv
// Types shared by the camera I/O block
package cio_pkg;
  typedef enum logic [2:0] {
    CIO_IDLE   = 3'b000,
    CIO_CLS_ON = 3'b001,
    CIO_CLS_OF = 3'b010,
    CIO_GAP    = 3'b011,
    CIO_COD_ON = 3'b100,
    CIO_COD_OF = 3'b101,
    CIO_PAUSE  = 3'b110
  } cio_blink_t;

  typedef struct packed {
    logic       invert;
    logic [4:0] mode;
  } cio_inp_cfg_t;
endpackage

//--- cio_top.sv
// Camera I/O trigger, outputs and status LED with AXI4-Lite registers
`timescale 1ns/1ps
`include "cio_map.svh"
module cio_top
  import cio_pkg::*;
#(
  parameter int unsigned SLOT_CYC = `CIO_BLINK_CYC
) (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write address
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Isolator outputs
  input  wire logic        general_input_one,
  input  wire logic        general_input_two,
  // Camera core status
  input  wire logic        bus_activity,
  input  wire logic        integration_active,
  input  wire logic        sensor_busy,
  input  wire logic        supply_good,
  // Capture start and outputs
  output logic             capture_start,
  output logic             general_output_one,
  output logic             general_output_two,
  output logic             general_output_three,
  output logic             general_output_four,
  // Bus port selection
  output logic             host_port_sel,
  output logic             repeat_enable,
  // Indicators and interrupt
  output logic             power_led,
  output logic             activity_class_led,
  output logic             trigger_code_led,
  output logic             irq
);
  cio_inp_cfg_t cfg [2];
  logic [3:0]   ctrl;
  logic [6:0]   fault;
  logic [11:0]  outsel;
  logic [3:0]   irq_stat;
  logic [3:0]   irq_mask;
  logic [1:0]   pin_level;
  logic [1:0]   cond_level;
  logic         trig_and;
  logic         trig_q;
  logic         waiting;
  logic         aw_held;
  logic         w_held;
  logic [11:0]  aw_addr;
  logic [31:0]  w_data;
  logic [3:0]   w_strb;
  logic         rd_stat;
  logic         fault_q;
  logic [1:0]   pin_q;
  logic [3:0]   events;
  logic         do_write;
  logic         arm_write;
  logic [3:0]   outs;

  cio_led_if led ();

  ////////////////////////////////////////////////////////////////////////////
  // Register decode
  function automatic logic known(input logic [11:0] a);
    unique case (a)
      `CIO_OFF_INP1, `CIO_OFF_INP2, `CIO_OFF_CTRL, `CIO_OFF_FAULT,
      `CIO_OFF_OUTSEL, `CIO_OFF_STATUS, `CIO_OFF_IRQ, `CIO_OFF_MASK:
        known = 1'b1;
      default: known = 1'b0;
    endcase
  endfunction

  function automatic logic [31:0] inp_word(input cio_inp_cfg_t c,
                                           input logic p);
    logic [31:0] w;
    w = `CIO_INP_RESET;
    w[`CIO_BIT_POL] = c.invert;
    w[`CIO_MODE_HI:`CIO_MODE_LO] = c.mode;
    w[`CIO_BIT_PIN] = p;
    inp_word = w;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Write channel: address and data in either order
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign do_write = aw_held && w_held;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= 12'h0;
      w_data  <= 32'h0;
      w_strb  <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (do_write) begin
        aw_held <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (do_write) begin
        w_held <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `CIO_RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= known(aw_addr) ? `CIO_RESP_OKAY : `CIO_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg[0]   <= '{invert: 1'b0, mode: `CIO_INP1_MODE};
      cfg[1]   <= '{invert: 1'b0, mode: 5'h00};
      ctrl     <= 4'h0;
      fault    <= 7'h00;
      outsel   <= `CIO_OUTSEL_RESET;
      irq_mask <= 4'h0;
    end else if (do_write && w_strb == 4'hf) begin
      unique case (aw_addr)
        `CIO_OFF_INP1: begin
          cfg[0].invert <= w_data[`CIO_BIT_POL];
          cfg[0].mode   <= w_data[`CIO_MODE_HI:`CIO_MODE_LO];
        end
        `CIO_OFF_INP2: begin
          cfg[1].invert <= w_data[`CIO_BIT_POL];
          cfg[1].mode   <= w_data[`CIO_MODE_HI:`CIO_MODE_LO];
        end
        `CIO_OFF_CTRL:   ctrl     <= w_data[3:0];
        `CIO_OFF_FAULT:  fault    <= w_data[6:0];
        `CIO_OFF_OUTSEL: outsel   <= w_data[11:0];
        `CIO_OFF_MASK:   irq_mask <= w_data[3:0];
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read channel
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0;
      s_axi_rresp  <= `CIO_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= known(s_axi_araddr) ? `CIO_RESP_OKAY
                                          : `CIO_RESP_SLVERR;
      unique case (s_axi_araddr)
        `CIO_OFF_INP1:   s_axi_rdata <= inp_word(cfg[0], pin_level[0]);
        `CIO_OFF_INP2:   s_axi_rdata <= inp_word(cfg[1], pin_level[1]);
        `CIO_OFF_CTRL:   s_axi_rdata <= {28'h0, ctrl};
        `CIO_OFF_FAULT:  s_axi_rdata <= {25'h0, fault};
        `CIO_OFF_OUTSEL: s_axi_rdata <= {20'h0, outsel};
        `CIO_OFF_STATUS: s_axi_rdata <= {26'h0, waiting, trig_and,
                                         cond_level, pin_level};
        `CIO_OFF_IRQ:    s_axi_rdata <= {28'h0, irq_stat};
        `CIO_OFF_MASK:   s_axi_rdata <= {28'h0, irq_mask};
        default:         s_axi_rdata <= 32'h0;
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  assign rd_stat = s_axi_arvalid && s_axi_arready &&
                   s_axi_araddr == `CIO_OFF_IRQ;

  ////////////////////////////////////////////////////////////////////////////
  // Trigger and capture
  cio_trig u_trig (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .iso_level  ({general_input_two, general_input_one}),
    .cfg        (cfg),
    .pin_level  (pin_level),
    .cond_level (cond_level),
    .trig_and   (trig_and)
  );

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      trig_q <= 1'b0;
    end else begin
      trig_q <= trig_and;
    end
  end

  // Rising edge of the combined trigger, only in external mode
  assign capture_start = ctrl[`CIO_CTRL_EXT] && trig_and && !trig_q;

  // Arming is decoded from the write itself, as ctrl is still old here
  assign arm_write = do_write && w_strb == 4'hf &&
                     aw_addr == `CIO_OFF_CTRL &&
                     w_data[`CIO_CTRL_EXT] && w_data[`CIO_CTRL_ARM];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      waiting <= 1'b0;
    end else if (capture_start) begin
      waiting <= 1'b0;
    end else if (arm_write) begin
      waiting <= 1'b1;
    end else if (!ctrl[`CIO_CTRL_EXT]) begin
      waiting <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Events and interrupt; set wins over read clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fault_q <= 1'b0;
      pin_q   <= 2'b00;
    end else begin
      fault_q <= fault[6];
      pin_q   <= pin_level;
    end
  end

  assign events[`CIO_EV_CAPTURE] = capture_start;
  assign events[`CIO_EV_FAULT]   = fault[6] && !fault_q;
  assign events[`CIO_EV_IN1]     = pin_level[0] ^ pin_q[0];
  assign events[`CIO_EV_IN2]     = pin_level[1] ^ pin_q[1];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat <= 4'h0;
    end else begin
      irq_stat <= (rd_stat ? 4'h0 : irq_stat) | events;
    end
  end

  assign irq = |(irq_stat & irq_mask);

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, bus ports and indicators
  genvar o;
  generate
    for (o = 0; o < 4; o++) begin : g_out
      always_comb begin
        unique case (outsel[3*o +: 3])
          `CIO_OUT_INTEGRATION_ACTIVE_OUTPUT: outs[o] = integration_active;
          `CIO_OUT_IN2:    outs[o] = cond_level[1];
          `CIO_OUT_BUSY:   outs[o] = sensor_busy;
          `CIO_OUT_TRIG:   outs[o] = trig_and;
          default:         outs[o] = 1'b0;
        endcase
      end
    end
  endgenerate

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      general_output_one   <= 1'b0;
      general_output_two   <= 1'b0;
      general_output_three <= 1'b0;
      general_output_four  <= 1'b0;
    end else begin
      general_output_one   <= outs[0];
      general_output_two   <= outs[1];
      general_output_three <= outs[2];
      general_output_four  <= outs[3];
    end
  end

  assign host_port_sel = ctrl[`CIO_CTRL_PORT];
  assign repeat_enable = 1'b1;
  assign power_led = supply_good && ctrl[`CIO_CTRL_READY];

  assign led.fault_on    = fault[6] && fault[5:3] != 3'h0 &&
                           fault[2:0] != 3'h0;
  assign led.fault_class = fault[5:3];
  assign led.fault_code  = fault[2:0];

  cio_blink #(.SLOT_CYC(SLOT_CYC)) u_blink (
    .aclk    (aclk),
    .aresetn (aresetn),
    .led     (led)
  );

  assign activity_class_led = led.blink_busy ? led.class_led
                                             : bus_activity;
  assign trigger_code_led   = led.blink_busy ? led.code_led
                                             : waiting;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  ext_only_a: assert property (@(posedge aclk) disable iff (!aresetn)
    capture_start |-> ctrl[`CIO_CTRL_EXT] && $rose(trig_and))
    else $error("Capture without external mode or trigger edge");
  wait_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
    capture_start |=> !waiting)
    else $error("Still waiting after trigger");
  fault_prio_a: assert property (@(posedge aclk) disable iff (!aresetn)
    led.fault_on |-> activity_class_led == led.class_led &&
    trigger_code_led == led.code_led)
    else $error("Normal indication shown during fault blinks");
  stat_sticky_a: assert property (@(posedge aclk) disable iff (!aresetn)
    capture_start |=> irq_stat[`CIO_EV_CAPTURE])
    else $error("Capture event lost");
endmodule

//--- cio_trig.sv
// Input conditioning and AND trigger for the two opto inputs
`timescale 1ns/1ps
`include "cio_map.svh"
module cio_trig
  import cio_pkg::*;
(
  // Clock and reset
  input  wire logic         aclk,
  input  wire logic         aresetn,
  // Raw isolator outputs and configuration
  input  wire logic [1:0]   iso_level,
  input  cio_inp_cfg_t      cfg [2],
  // Conditioned levels and trigger
  output logic [1:0]        pin_level,
  output logic [1:0]        cond_level,
  output logic              trig_and
);
  logic [1:0] is_trig;

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_in
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          pin_level[g]  <= 1'b0;
          cond_level[g] <= 1'b0;
        end else begin
          pin_level[g]  <= ~iso_level[g];
          cond_level[g] <= ~iso_level[g] ^ cfg[g].invert;
        end
      end
      assign is_trig[g] = (cfg[g].mode == `CIO_MODE_TRIG);
    end
  endgenerate

  // AND over trigger inputs; no trigger input means no trigger
  assign trig_and = (|is_trig) &&
                    ((cond_level | ~is_trig) == 2'b11);

  and_trig_a: assert property (@(posedge aclk) disable iff (!aresetn)
    trig_and |-> is_trig != 2'b00 &&
    (cond_level & is_trig) == is_trig)
    else $error("Trigger high with a trigger input low");
endmodule

//--- testbench.sv
// Self-checking bench of the camera I/O block
`timescale 1ns/1ps
`include "cio_map.svh"
module testbench;
  logic        aclk, aresetn;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb, class_blinks, code_blinks;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready, drive_one, drive_two;
  logic        general_input_one, general_input_two, capture_start;
  logic        bus_activity, integration_active, sensor_busy, supply_good;
  logic        general_output_one, general_output_two, general_output_three;
  logic        general_output_four, host_port_sel, repeat_enable;
  logic        power_led, activity_class_led, trigger_code_led, irq;
  int          pauses, failures, samples_checked, cycles, captures, n;
  logic [5:0]  faults [13] = '{6'h21, 6'h22, 6'h23, 6'h24, 6'h25, 6'h29,
                                6'h2a, 6'h19, 6'h11, 6'h13, 6'h09, 6'h0a,
                                6'h0b};

  cio_top #(.SLOT_CYC(4)) u_cio_top (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .general_input_one, .general_input_two, .bus_activity,
    .integration_active, .sensor_busy, .supply_good, .capture_start,
    .general_output_one, .general_output_two, .general_output_three,
    .general_output_four, .host_port_sel, .repeat_enable, .power_led,
    .activity_class_led, .trigger_code_led, .irq);
  cio_far_end #(.SLOT_CYC(4)) u_cio_far_end (
    .aclk, .drive_one, .drive_two, .iso_one(general_input_one),
    .iso_two(general_input_two), .class_led(activity_class_led),
    .code_led(trigger_code_led), .class_blinks, .code_blinks, .pauses);

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    $display("Checked %0d, failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic rchk(input logic [11:0] a, input logic [31:0] e);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    chk(rd, e);
  endtask

  task automatic at_neg(input int k);
    repeat (k) @(posedge aclk);
    @(negedge aclk);
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end

  always @(posedge aclk) begin
    cycles++;
    if (capture_start === 1'b1) captures++;
    if (cycles == 20000) begin
      failures++;
      conclude();
    end
  end

  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
    {s_axi_wdata, drive_one, drive_two, bus_activity} = '0;
    {integration_active, sensor_busy} = '0;
    s_axi_wstrb = 4'hf;
    supply_good = 1'b1;
    {failures, samples_checked, cycles, captures} = '0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    rchk(`CIO_OFF_INP1, 32'h00001001);
    rchk(`CIO_OFF_INP2, 32'h00000001);
    rchk(`CIO_OFF_OUTSEL, 32'h000000d1);
    rchk(12'h3f0, 32'h0);
    chk({30'h0, rsp}, {30'h0, `CIO_RESP_SLVERR});
    wr(12'h3f0, 32'h0);
    chk({30'h0, rsp}, {30'h0, `CIO_RESP_SLVERR});
    wr(`CIO_OFF_MASK, 32'h1);
    chk({30'h0, rsp}, {30'h0, `CIO_RESP_OKAY});
    wr(`CIO_OFF_CTRL, 32'h7);
    at_neg(1);
    chk({30'h0, trigger_code_led, power_led}, 32'h3);
    rchk(`CIO_OFF_STATUS, 32'h20);
    bus_activity <= 1'b1;
    at_neg(2);
    chk({31'h0, activity_class_led}, 32'h1);
    @(posedge aclk);
    bus_activity <= 1'b0;
    drive_one <= 1'b1;
    at_neg(4);
    chk({29'h0, irq, trigger_code_led, activity_class_led}, 32'h4);
    chk(captures, 1);
    rchk(`CIO_OFF_STATUS, 32'h15);
    rchk(`CIO_OFF_IRQ, 32'h5);
    rchk(`CIO_OFF_IRQ, 32'h0);
    at_neg(1);
    chk({31'h0, irq}, 32'h0);
    wr(`CIO_OFF_INP1, 32'h1080);
    rchk(`CIO_OFF_STATUS, 32'h01);
    wr(`CIO_OFF_INP2, 32'h1000);
    wr(`CIO_OFF_INP1, 32'h1000);
    rchk(`CIO_OFF_STATUS, 32'h05);
    @(posedge aclk);
    drive_two <= 1'b1;
    rchk(`CIO_OFF_STATUS, 32'h1f);
    chk(captures, 2);
    wr(`CIO_OFF_CTRL, 32'h4);
    drive_one <= 1'b0;
    at_neg(3);
    @(posedge aclk);
    drive_one <= 1'b1;
    sensor_busy <= 1'b1;
    integration_active <= 1'b1;
    at_neg(4);
    chk(captures, 2);
    wr(`CIO_OFF_OUTSEL, 32'h8d1);
    at_neg(3);
    chk({general_output_four, general_output_three, general_output_two,
         general_output_one}, 4'hf);
    wr(`CIO_OFF_CTRL, 32'hc);
    @(posedge aclk);
    supply_good <= 1'b0;
    at_neg(1);
    chk({host_port_sel, repeat_enable, power_led}, 3'b110);
    wr(`CIO_OFF_MASK, 32'h2);
    bus_activity <= 1'b1;
    foreach (faults[i]) begin
      wr(`CIO_OFF_FAULT, {25'h0, 1'b1, faults[i]});
      at_neg(1);
      if (i == 0) chk({31'h0, irq}, 32'h1);
      n = pauses;
      wait (pauses == n + 1);
      for (int k = 0; k < 2; k++) begin
        wait (pauses == n + 2 + k);
        @(negedge aclk);
        chk({28'h0, class_blinks}, {29'h0, faults[i][5:3]});
        chk({28'h0, code_blinks}, {29'h0, faults[i][2:0]});
      end
    end
    wr(`CIO_OFF_FAULT, 32'h0);
    at_neg(160);
    chk({30'h0, activity_class_led, trigger_code_led}, 32'h2);
    conclude();
  end
endmodule
